// ---- hw/brk_pkg.sv ----
// constants for the address breakpoint unit
package brk_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL   = 8'h00; // enable and active flag
  localparam logic [7:0] OFF_ADDRH  = 8'h04;
  localparam logic [7:0] OFF_ADDRL  = 8'h08;
  localparam logic [7:0] OFF_FLAGC  = 8'h0c; // flag clear enable
  localparam logic [7:0] OFF_IRQST  = 8'h10;
  localparam logic [7:0] OFF_IRQMSK = 8'h14;
  // field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_FCE    = 7;
  localparam int IRQ_ENTER  = 0;
  localparam int IRQ_EXIT   = 1;
  // vectors, reset values and the break state type
  localparam logic [15:0] VEC_NORMAL  = 16'hfffc;
  localparam logic [15:0] VEC_MONITOR = 16'hfefc;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [1:0]  RST_IRQ     = 2'h0;
  typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_BREAK} brk_state_t;
endpackage

// ---- hw/addr_match.sv ----
// full-width comparator of the program counter against the break address
module addr_match #(
  parameter int AW = 16
) (
  input  wire logic [AW-1:0] pc,
  input  wire logic [AW-1:0] brk_addr,
  input  wire logic          fetch,
  input  wire logic          enable,
  output logic               hit
);
  // only a cpu-generated fetch address counts, data addresses are ignored
  assign hit = enable & fetch & (pc == brk_addr);
endmodule

// ---- hw/address_breakpoint_unit.sv ----
// address breakpoint unit with ahb-lite register slave
module address_breakpoint_unit
  import brk_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic [AW-1:0] cpu_pc,
  input  wire logic          cpu_fetch,
  input  wire logic          cpu_insn_boundary,
  input  wire logic          cpu_rti,
  input  wire logic          monitor_mode,
  input  wire logic          periph_clear_req,
  output logic               breakpoint_request,
  output logic               force_swi,
  output logic [AW-1:0]      break_vector,
  output logic               break_state,
  output logic               watchdog_hold,
  output logic               periph_clear_allow,
  output logic               irq
);
  import brk_pkg::*;

  logic [7:0]  addr_high_reg;
  logic [7:0]  addr_low_reg;
  logic        enable_reg;
  logic        active_reg;
  logic        fce_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_mask_reg;
  logic        pend_reg;
  brk_state_t  state_reg;
  brk_state_t  state_next;
  logic        wr_pend_reg;
  logic [7:0]  wr_off_reg;
  logic [31:0] hrdata_reg;
  logic        match_hit;

  // address phase decode
  wire       ap_valid = hsel & hready & htrans[1];
  wire       ap_write = ap_valid & hwrite;
  wire       ap_read  = ap_valid & ~hwrite;
  wire [7:0] ap_off   = haddr[7:0];

  // data phase write strobes
  wire wr_ctrl  = wr_pend_reg && wr_off_reg == OFF_CTRL;
  wire wr_addrh = wr_pend_reg && wr_off_reg == OFF_ADDRH;
  wire wr_addrl = wr_pend_reg && wr_off_reg == OFF_ADDRL;
  wire wr_flagc = wr_pend_reg && wr_off_reg == OFF_FLAGC;
  wire wr_irqst = wr_pend_reg && wr_off_reg == OFF_IRQST;
  wire wr_irqmk = wr_pend_reg && wr_off_reg == OFF_IRQMSK;

  // zero-wait slave, every access answered okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  addr_match #(
    .AW(AW)
  ) u_match (
    .pc       (cpu_pc),
    .fetch    (cpu_fetch),
    .brk_addr ({addr_high_reg, addr_low_reg}),
    .enable   (enable_reg),
    .hit      (match_hit)
  );

  // break sources: address hit, or software writing one to the active flag
  wire sw_trigger = wr_ctrl & hwdata[BIT_ACTIVE];
  wire trigger    = (match_hit | sw_trigger) & (state_reg == ST_RUN);
  wire entering   = state_reg == ST_ENTER;
  wire break_done = (state_reg == ST_BREAK) & cpu_rti;

  // the request is held to the next instruction boundary so a software
  // trigger lands just before the next instruction, not mid-instruction
  assign breakpoint_request = match_hit | pend_reg;
  assign force_swi          = entering & cpu_insn_boundary;
  assign break_vector       = monitor_mode ? VEC_MONITOR : VEC_NORMAL;
  assign break_state        = state_reg != ST_RUN;
  assign watchdog_hold      = break_state;
  // suppress peripheral flag clears during break unless enabled
  assign periph_clear_allow = periph_clear_req & (~break_state | fce_reg);
  assign irq                = |(irq_status_reg & irq_mask_reg);

  // break sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN:   if (trigger) state_next = ST_ENTER;
      ST_ENTER: if (cpu_insn_boundary) state_next = ST_BREAK;
      ST_BREAK: if (cpu_rti) state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RUN;
      pend_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_reg  <= (trigger | pend_reg) & ~force_swi;
    end
  end

  // bus pipeline register for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_off_reg  <= RST_BYTE;
    end else begin
      wr_pend_reg <= ap_write;
      wr_off_reg  <= ap_off;
    end
  end

  // break address bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_high_reg <= RST_BYTE;
      addr_low_reg  <= RST_BYTE;
    end else begin
      if (wr_addrh) addr_high_reg <= hwdata[7:0];
      if (wr_addrl) addr_low_reg  <= hwdata[7:0];
    end
  end

  // enable, flag clear enable, active flag; a match beats a clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= 1'b0;
      active_reg <= 1'b0;
      fce_reg    <= 1'b0;
    end else begin
      if (wr_ctrl) enable_reg <= hwdata[BIT_ENABLE];
      if (wr_flagc) fce_reg <= hwdata[BIT_FCE];
      if (match_hit) active_reg <= 1'b1;
      else if (wr_ctrl) active_reg <= hwdata[BIT_ACTIVE];
    end
  end

  // sticky events: break entered, break ended; set wins over clear
  wire [1:0] irq_set = {break_done, force_swi};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= RST_IRQ;
      irq_mask_reg   <= RST_IRQ;
    end else begin
      irq_status_reg <= irq_set | (irq_status_reg & ~({2{wr_irqst}} & hwdata[1:0]));
      if (wr_irqmk) irq_mask_reg <= hwdata[1:0];
    end
  end

  // read mux, unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (ap_off)
      OFF_CTRL:   rd_mux = {24'h0, enable_reg, active_reg, 6'h0};
      OFF_ADDRH:  rd_mux = {24'h0, addr_high_reg};
      OFF_ADDRL:  rd_mux = {24'h0, addr_low_reg};
      OFF_FLAGC:  rd_mux = {24'h0, fce_reg, 7'h0};
      OFF_IRQST:  rd_mux = {30'h0, irq_status_reg};
      OFF_IRQMSK: rd_mux = {30'h0, irq_mask_reg};
      default:    rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata_reg <= 32'h0;
    else if (ap_read) hrdata_reg <= rd_mux;
  end

  // checks
  a_match_request: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable_reg && cpu_fetch && cpu_pc == {addr_high_reg, addr_low_reg}) |-> breakpoint_request)
    else $error("match without request");
  a_no_match_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (!enable_reg && !pend_reg) |-> !breakpoint_request)
    else $error("request while disabled");
  a_match_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    match_hit |=> active_reg)
    else $error("active flag not set");
  a_vector_select: assert property (@(posedge hclk) disable iff (!hresetn)
    break_vector == (monitor_mode ? 16'hfefc : 16'hfffc))
    else $error("wrong break vector");
  a_swi_enter: assert property (@(posedge hclk) disable iff (!hresetn)
    force_swi |=> state_reg == ST_BREAK)
    else $error("swi without break");
  a_rti_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == ST_BREAK && cpu_rti) |=> !break_state)
    else $error("rti did not end break");
  a_wdog_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(break_state) |-> watchdog_hold)
    else $error("watchdog runs in break");
  a_sw_trigger: assert property (@(posedge hclk) disable iff (!hresetn)
    (sw_trigger && state_reg == ST_RUN) |=> state_reg == ST_ENTER)
    else $error("software break lost");
  a_clear_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (break_state && !fce_reg) |-> !periph_clear_allow)
    else $error("clear passed in break");
endmodule

// ---- dv/cpu_model.sv ----
// cpu core and integration unit stand-in driving fetch addresses
module cpu_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        force_swi,
  input  wire logic        break_state,
  input  wire logic [15:0] break_vector,
  input  wire logic        load,
  input  wire logic [15:0] load_pc,
  input  wire logic        fetch_off,
  input  wire logic        slow,
  input  wire logic        rti_req,
  output logic [15:0]      cpu_pc,
  output logic             cpu_fetch,
  output logic             cpu_insn_boundary,
  output logic             cpu_rti
);
  timeunit 1ns;
  timeprecision 100ps;
  assign cpu_fetch = ~fetch_off; // operand cycles carry no fetch address
  // pc steps every cycle; slow mode offers a boundary only every other cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_pc <= 16'h0000;
      cpu_insn_boundary <= 1'b0;
      cpu_rti <= 1'b0;
    end else begin
      cpu_pc <= force_swi ? break_vector : (load ? load_pc : cpu_pc + 16'h0001);
      cpu_insn_boundary <= slow ? ~cpu_insn_boundary : 1'b1;
      cpu_rti <= rti_req & break_state & ~cpu_rti;
    end
  end
endmodule

// ---- dv/address_breakpoint_unit_tb.sv ----
// self-checking bench for the address breakpoint unit
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %0t mismatch", $time); end end
module address_breakpoint_unit_tb;
  import brk_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, load = 0, fetch_off = 0, slow = 0, rti_req = 0;
  logic mon = 0, pclr = 0, rd_dp = 0, hreadyout, hresp, fetch, bound, return_from_interrupt_instruction, breq, fswi, bst, wdh, pallow, irq;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] load_pc = 16'h0, pc, bvec, a;
  logic [31:0] q[$];
  int          error_cnt = 0, checks_done = 0, cyc = 0, nswi = 0;
  always #2 hclk = ~hclk;
  address_breakpoint_unit u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_pc(pc), .cpu_fetch(fetch), .cpu_insn_boundary(bound),
    .cpu_rti(return_from_interrupt_instruction), .monitor_mode(mon), .periph_clear_req(pclr), .breakpoint_request(breq), .force_swi(fswi),
    .break_vector(bvec), .break_state(bst), .watchdog_hold(wdh), .periph_clear_allow(pallow), .irq);
  cpu_model u_cpu (.hclk, .hresetn, .force_swi(fswi), .break_state(bst), .break_vector(bvec), .load, .load_pc,
    .fetch_off, .slow, .rti_req, .cpu_pc(pc), .cpu_fetch(fetch), .cpu_insn_boundary(bound), .cpu_rti(return_from_interrupt_instruction));
  // read data leaves the queue in its data phase
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) begin
      `CHK(hrdata, q.pop_front())
      `CHK(hresp, 1'b0)
    end
  end
  // cycle limit cuts a hang; also counts swi substitutions
  always @(posedge hclk) begin
    cyc++;
    nswi += int'(fswi === 1'b1);
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // single word transfer; the address phase is held until hready
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= ~w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    q.push_back(e);
    bus(ad, 1'b0, 32'h0);
  endtask
  task automatic wt(input logic v);
    for (int i = 0; i < 20 && bst !== v; i++) @(posedge hclk);
    #1 `CHK(bst, v)
  endtask
  // jump the cpu four bytes short of the break address and watch the request
  task automatic run(input logic e);
    load <= 1'b1;
    load_pc <= a - 16'h0004;
    @(posedge hclk);
    load <= 1'b0;
    // look a little after each edge so the request and pc have settled
    for (int i = 0; i < 10 && breq !== 1'b1; i++) begin
      @(posedge hclk);
      #1;
    end
    `CHK(breq, e)
    if (e) `CHK(pc, a)
  endtask
  initial begin
    void'($urandom(13));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    for (int o = 0; o <= 24; o += 4) rd(8'(o), 32'h0);
    a = 16'($urandom_range(32'hff00, 32'h0100));
    bus(OFF_ADDRH, 1'b1, {24'h0, a[15:8]});
    bus(OFF_ADDRL, 1'b1, {24'h0, a[7:0]});
    rd(OFF_ADDRL, {24'h0, a[7:0]});
    run(1'b0);
    bus(OFF_CTRL, 1'b1, 32'h80);
    fetch_off <= 1'b1;
    run(1'b0);
    fetch_off <= 1'b0;
    mon <= 1'($urandom);
    run(1'b1);
    wt(1'b1);
    `CHK(nswi, 1)
    `CHK(bvec, mon ? VEC_MONITOR : VEC_NORMAL)
    `CHK(wdh, 1'b1)
    rd(OFF_CTRL, 32'hc0);
    rd(OFF_IRQST, 32'h1);
    bus(OFF_IRQMSK, 1'b1, 32'h3);
    #1 `CHK(irq, 1'b1)
    pclr <= 1'b1;
    #1 `CHK(pallow, 1'b0)
    bus(OFF_FLAGC, 1'b1, 32'h80);
    #1 `CHK(pallow, 1'b1)
    bus(OFF_CTRL, 1'b1, 32'h0);
    rti_req <= 1'b1;
    wt(1'b0);
    rti_req <= 1'b0;
    rd(OFF_CTRL, 32'h0);
    rd(OFF_IRQST, 32'h3);
    bus(OFF_IRQST, 1'b1, 32'h3);
    #1 `CHK(irq, 1'b0)
    slow <= 1'b1;
    mon <= 1'($urandom);
    bus(OFF_CTRL, 1'b1, 32'h40);
    wt(1'b1);
    // slow cpu offers a boundary only every other cycle, so let the swi land
    repeat (3) @(posedge hclk);
    #1;
    `CHK(nswi, 2)
    `CHK(bvec, mon ? VEC_MONITOR : VEC_NORMAL)
    bus(OFF_CTRL, 1'b1, 32'h0);
    rti_req <= 1'b1;
    wt(1'b0);
    test_done();
  end
endmodule
